// ==== i2c_slave_pkg.sv ====
// Constants and types shared by the register access slave
package i2c_slave_pkg;

	localparam int        DEV_ADDR_W  = 7;
	localparam int        BYTE_W      = 8;
	localparam int        PTR_W       = 16;
	localparam logic [3:0] BIT_LAST   = 4'h8;
	localparam logic [3:0] TX_LAST    = 4'h7;
	localparam logic [1:0] IDX_HI     = 2'h0;
	localparam logic [1:0] IDX_LO     = 2'h1;
	localparam logic [1:0] IDX_DATA   = 2'h2;
	localparam logic [15:0] PTR_RST   = 16'h0000;
	localparam logic [15:0] PTR_ONE   = 16'h0001;
	// Arbitrary default slave address
	localparam logic [6:0] DEF_DEV_ADDR = 7'h55;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_ACK  = 3'h2,
		ST_RX   = 3'h3,
		ST_TX   = 3'h4,
		ST_MACK = 3'h5
	} slave_state_e;

endpackage

// ==== line_events_if.sv ====
// Interface carrying synchronised bus lines and detected bus events
`timescale 1ns/1ps
`default_nettype none
interface line_events_if;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;

	modport src (output scl, output sda, output scl_rise, output scl_fall,
		output start, output stop);
	modport dst (input scl, input sda, input scl_rise, input scl_fall,
		input start, input stop);
endinterface
`default_nettype wire

// ==== i2c_line_sampler.sv ====
// Synchroniser and edge, start and stop detector for SCL and SDA
`timescale 1ns/1ps
`default_nettype none
module i2c_line_sampler (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// Bus pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	// Events
	line_events_if.src      ev
);
	import i2c_slave_pkg::*;

	logic [1:0] scl_meta_r;
	logic [1:0] sda_meta_r;
	logic       scl_s_r;
	logic       sda_s_r;
	logic       scl_p_r;
	logic       sda_p_r;

	// First stage feeds only the second
	always_ff @(posedge clock) begin
		if (rst) begin
			scl_meta_r <= 2'h3;
			sda_meta_r <= 2'h3;
		end else begin
			scl_meta_r <= {scl_meta_r[0], scl_in};
			sda_meta_r <= {sda_meta_r[0], sda_in};
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			scl_s_r <= 1'h1;
			sda_s_r <= 1'h1;
			scl_p_r <= 1'h1;
			sda_p_r <= 1'h1;
		end else begin
			scl_s_r <= scl_meta_r[1];
			sda_s_r <= sda_meta_r[1];
			scl_p_r <= scl_s_r;
			sda_p_r <= sda_s_r;
		end
	end

	assign ev.scl      = scl_s_r;
	assign ev.sda      = sda_s_r;
	assign ev.scl_rise = scl_s_r & ~scl_p_r;
	assign ev.scl_fall = ~scl_s_r & scl_p_r;
	// SDA moving while SCL stays high marks start or stop
	assign ev.start    = scl_s_r & scl_p_r & sda_p_r & ~sda_s_r;
	assign ev.stop     = scl_s_r & scl_p_r & ~sda_p_r & sda_s_r;

	// Checked against the pins, three and four edges back, not the detector's own terms
	AST_START_NEEDS_SCL_HIGH: assert property (@(posedge clock) disable iff (rst)
		ev.start |-> $past(scl_in, 3) && $past(scl_in, 4) && $past(sda_in, 4)
			&& !$past(sda_in, 3))
		else $error("start flagged without SDA falling under high SCL");
endmodule
`default_nettype wire

// ==== i2c_register_access_slave.sv ====
// I2C slave engine giving 16-bit addressed access to control registers
`timescale 1ns/1ps
`default_nettype none
module i2c_register_access_slave #(
	parameter logic [6:0] OWN_ADDR = i2c_slave_pkg::DEF_DEV_ADDR
) (
	// Clock and reset
	input  wire logic                         clock,
	input  wire logic                         rst,
	// Bus pins, SDA is open drain
	input  wire logic                         scl_in,
	input  wire logic                         sda_in,
	output logic                              sda_out,
	output logic                              sda_oe,
	// Configuration
	input  wire logic                         ascend,
	// Register port
	output logic [i2c_slave_pkg::PTR_W-1:0]   reg_addr,
	output logic [i2c_slave_pkg::BYTE_W-1:0]  reg_wdata,
	output logic                              reg_wr,
	input  wire logic [i2c_slave_pkg::BYTE_W-1:0] reg_rdata
);
	import i2c_slave_pkg::*;

	line_events_if ev ();

	slave_state_e      st_r;
	logic [BYTE_W-1:0] shift_r;
	logic [BYTE_W-1:0] tx_r;
	logic [3:0]        cnt_r;
	logic [1:0]        idx_r;
	logic              rw_r;
	logic              sda_oe_r;
	logic              sda_out_r;
	logic [PTR_W-1:0]  ptr_r;
	logic [BYTE_W-1:0] wdata_r;
	logic              wr_r;
	logic              byte_done;
	logic              addr_hit;
	logic              mack_edge;
	logic [PTR_W-1:0]  ptr_step;

	i2c_line_sampler u_sampler (
		.clock  (clock),
		.rst    (rst),
		.scl_in (scl_in),
		.sda_in (sda_in),
		.ev     (ev)
	);

	assign byte_done = ev.scl_fall && (cnt_r == BIT_LAST);
	assign addr_hit  = (shift_r[BYTE_W-1:1] == OWN_ADDR);
	assign mack_edge = (st_r == ST_MACK) && ev.scl_rise;
	// Plain 16-bit wrap; the register map decides what lies beyond its top
	assign ptr_step  = ascend ? ptr_r + PTR_ONE : ptr_r - PTR_ONE;

	////////////////////////////////////////////////////////////////////////
	// Bit sequencing and SDA drive

	always_ff @(posedge clock) begin
		if (rst) begin
			st_r     <= ST_IDLE;
			rw_r     <= 1'h0;
			sda_oe_r <= 1'h0;
			tx_r     <= '0;
		end else if (ev.start) begin
			st_r     <= ST_ADDR;
			sda_oe_r <= 1'h0;
		end else if (ev.stop) begin
			st_r     <= ST_IDLE;
			sda_oe_r <= 1'h0;
		end else begin
			case (st_r)
			ST_ADDR: begin
				if (byte_done) begin
					if (addr_hit) begin
						rw_r     <= shift_r[0];
						sda_oe_r <= 1'h1;
						st_r     <= ST_ACK;
					end else begin
						st_r     <= ST_IDLE;
					end
				end
			end
			ST_RX: begin
				if (byte_done) begin
					sda_oe_r <= 1'h1;
					st_r     <= ST_ACK;
				end
			end
			ST_ACK: begin
				if (ev.scl_fall) begin
					if (rw_r) begin
						tx_r     <= reg_rdata;
						sda_oe_r <= ~reg_rdata[BYTE_W-1];
						st_r     <= ST_TX;
					end else begin
						sda_oe_r <= 1'h0;
						st_r     <= ST_RX;
					end
				end
			end
			ST_TX: begin
				if (ev.scl_fall) begin
					if (cnt_r == TX_LAST) begin
						sda_oe_r <= 1'h0;
						st_r     <= ST_MACK;
					end else begin
						tx_r     <= {tx_r[BYTE_W-2:0], 1'h0};
						sda_oe_r <= ~tx_r[BYTE_W-2];
					end
				end
			end
			ST_MACK: begin
				if (ev.scl_rise) begin
					// Master acknowledge rejoins the ack path; no-acknowledge quits
					st_r <= ev.sda ? ST_IDLE : ST_ACK;
				end
			end
			default: begin
				st_r     <= ST_IDLE;
				sda_oe_r <= 1'h0;
			end
			endcase
		end
	end

	// Open drain: the driven level is always low
	always_ff @(posedge clock) begin
		if (rst) begin
			sda_out_r <= 1'h0;
		end else begin
			sda_out_r <= 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shift register, bit count and byte index

	always_ff @(posedge clock) begin
		if (rst) begin
			shift_r <= '0;
			cnt_r   <= '0;
			idx_r   <= IDX_HI;
		end else if (ev.start || ev.stop) begin
			cnt_r   <= '0;
			idx_r   <= IDX_HI;
		end else if ((st_r == ST_ADDR || st_r == ST_RX) && ev.scl_rise) begin
			shift_r <= {shift_r[BYTE_W-2:0], ev.sda};
			cnt_r   <= cnt_r + 4'h1;
		end else if (st_r == ST_TX && ev.scl_fall) begin
			cnt_r   <= cnt_r + 4'h1;
		end else if (st_r == ST_ACK && ev.scl_fall) begin
			cnt_r   <= '0;
		end else if (st_r == ST_MACK) begin
			cnt_r   <= '0;
		end else if (st_r == ST_RX && byte_done && idx_r != IDX_DATA) begin
			idx_r   <= idx_r + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register pointer and write strobe

	always_ff @(posedge clock) begin
		if (rst) begin
			ptr_r <= PTR_RST;
		end else if (st_r == ST_RX && byte_done && idx_r == IDX_HI) begin
			ptr_r[15:8] <= shift_r;
		end else if (st_r == ST_RX && byte_done && idx_r == IDX_LO) begin
			ptr_r[7:0]  <= shift_r;
		end else if (wr_r || mack_edge) begin
			ptr_r <= ptr_step;
		end
	end

	// Stepping waits for the strobe cycle so the write sees the old pointer
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_r    <= 1'h0;
			wdata_r <= '0;
		end else begin
			wr_r    <= (st_r == ST_RX) && byte_done && (idx_r == IDX_DATA) && !ev.start
				&& !ev.stop;
			wdata_r <= shift_r;
		end
	end

	assign sda_out   = sda_out_r;
	assign sda_oe    = sda_oe_r;
	assign reg_addr  = ptr_r;
	assign reg_wdata = wdata_r;
	assign reg_wr    = wr_r;

	////////////////////////////////////////////////////////////////////////
	// Checks

	AST_START_OPENS_ADDR: assert property (@(posedge clock) disable iff (rst)
		ev.start |=> st_r == ST_ADDR && cnt_r == 4'h0 && !sda_oe_r)
		else $error("start did not open an address byte");
	AST_STOP_IDLES: assert property (@(posedge clock) disable iff (rst)
		ev.stop |=> st_r == ST_IDLE && !wr_r && !sda_oe_r)
		else $error("stop did not return to idle cleanly");
	AST_MISMATCH_IGNORED: assert property (@(posedge clock) disable iff (rst)
		st_r == ST_ADDR && byte_done && !addr_hit && !ev.start && !ev.stop
		|=> (st_r == ST_IDLE && !sda_oe_r) [*2])
		else $error("foreign address not ignored");
	AST_MATCH_ACKED: assert property (@(posedge clock) disable iff (rst)
		st_r == ST_ADDR && byte_done && addr_hit && !ev.start && !ev.stop
		|=> sda_oe_r && st_r == ST_ACK && rw_r == $past(shift_r[0]))
		else $error("own address not acknowledged");
	AST_NACK_IDLES: assert property (@(posedge clock) disable iff (rst)
		mack_edge && ev.sda && !ev.start && !ev.stop |=> st_r == ST_IDLE)
		else $error("no-acknowledge did not end the read");
	AST_HIGH_BYTE_FIRST: assert property (@(posedge clock) disable iff (rst)
		st_r == ST_RX && byte_done && idx_r == IDX_HI && !ev.start && !ev.stop
		|=> ptr_r[15:8] == $past(shift_r) && !wr_r)
		else $error("high pointer byte not loaded first");
	AST_WRITE_ONLY_DATA: assert property (@(posedge clock) disable iff (rst)
		wr_r |-> $past(idx_r) == IDX_DATA)
		else $error("pointer byte written to a register");
	AST_POINTER_STEP: assert property (@(posedge clock) disable iff (rst)
		wr_r |=> ptr_r == ($past(ascend) ? $past(ptr_r) + PTR_ONE
			: $past(ptr_r) - PTR_ONE))
		else $error("pointer did not step by one");
	AST_TX_FIRST_BIT: assert property (@(posedge clock) disable iff (rst)
		st_r == ST_ACK && rw_r && ev.scl_fall && !ev.start && !ev.stop
		|=> st_r == ST_TX && sda_oe_r == !$past(reg_rdata[BYTE_W-1]))
		else $error("read data did not start after acknowledge");
	AST_DRIVE_SCL_LOW: assert property (@(posedge clock) disable iff (rst)
		$rose(sda_oe_r) |-> !ev.scl)
		else $error("SDA pulled while SCL high");

	COV_WRITE:    cover property (@(posedge clock) disable iff (rst) wr_r ##[1:400] wr_r);
	COV_READ_ACK: cover property (@(posedge clock) disable iff (rst) mack_edge && !ev.sda);
	COV_NACK:     cover property (@(posedge clock) disable iff (rst) mack_edge && ev.sda);
	COV_RESTART:  cover property (@(posedge clock) disable iff (rst)
		ev.start && st_r == ST_RX);
endmodule
`default_nettype wire

// ==== i2c_master_model.sv ====
// Behavioural I2C bus master driving SCL and pulling SDA low
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
	// Clock
	input  wire logic clock,
	// Bus
	input  wire logic sda_bus,
	output var  logic scl,
	output var  logic sda_low
);
	initial begin
		scl     = 1'b1;
		sda_low = 1'b0;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// SCL low 5 cycles, high 3; device answers about 4 cycles after a fall
	task automatic bit_x(input logic b, output logic r);
		cyc(1);
		sda_low = ~b;
		cyc(4);
		scl = 1'b1;
		cyc(3);
		r   = sda_bus;
		scl = 1'b0;
	endtask

	task automatic start_c();
		cyc(1);
		sda_low = 1'b0;
		cyc(4);
		scl = 1'b1;
		cyc(3);
		sda_low = 1'b1;
		cyc(4);
		scl = 1'b0;
	endtask

	task automatic stop_c();
		cyc(1);
		sda_low = 1'b1;
		cyc(4);
		scl = 1'b1;
		cyc(3);
		sda_low = 1'b0;
		cyc(4);
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r);
		bit_x(1'b1, r);
		ack = ~r;
	endtask

	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(last, r);
	endtask
endmodule
`default_nettype wire

// ==== tb_i2c_register_access_slave.sv ====
// Self-checking testbench for the I2C register access slave
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_register_access_slave;
	import i2c_slave_pkg::*;

	typedef struct packed {
		logic [15:0] ptr;
		logic        asc;
		logic [7:0]  d;
		logic [15:0] step;
	} row_s;

	// Arbitrary slave address, not the default
	localparam logic [6:0] ADDR = 7'h2a;
	localparam int         NB   = 3;

	logic              clock   = 1'b0;
	logic              rst     = 1'b1;
	logic              ascend  = 1'b1;
	logic              scl;
	logic              sda_low;
	logic              sda_out;
	logic              sda_oe;
	logic              reg_wr;
	logic [PTR_W-1:0]  reg_addr;
	logic [BYTE_W-1:0] reg_wdata;
	logic [BYTE_W-1:0] reg_rdata;
	logic [7:0]        mem [0:255];
	logic              ack;
	logic [7:0]        rd;
	int                miscompares = 0;
	int                checks_done = 0;
	int                wr_count    = 0;
	int                base;
	// Wrap-around rows cross both ends of the pointer range
	row_s              rows [4] = '{'{16'h1234, 1'b1, 8'h5a, 16'h0001},
		'{16'h0102, 1'b0, 8'hc3, 16'hffff}, '{16'h0000, 1'b0, 8'h81, 16'hffff},
		'{16'hfffe, 1'b1, 8'h3c, 16'h0001}};

	// Pull-up on SDA: high unless someone pulls it low
	wire logic sda_bus = (sda_oe ? sda_out : 1'b1) & ~sda_low;
	assign reg_rdata = mem[reg_addr[7:0]];

	always #25 clock = ~clock;

	always @(posedge clock) begin
		if (reg_wr === 1'b1) begin
			mem[reg_addr[7:0]] <= reg_wdata;
			wr_count <= wr_count + 1;
		end
	end

	i2c_register_access_slave #(.OWN_ADDR(ADDR)) u_dut (
		.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda_bus),
		.sda_out(sda_out), .sda_oe(sda_oe), .ascend(ascend), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata));

	i2c_master_model u_master (
		.clock(clock), .sda_bus(sda_bus), .scl(scl), .sda_low(sda_low));

	////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic put(input logic [7:0] d);
		u_master.wbyte(d, ack);
		chk_bit(ack, 1'b1);
	endtask

	task automatic set_ptr(input logic [15:0] p);
		u_master.start_c();
		put({ADDR, 1'b0});
		put(p[15:8]);
		put(p[7:0]);
		chk_val(reg_addr[15:8], p[15:8]);
		chk_val(reg_addr[7:0], p[7:0]);
	endtask

	task automatic final_report();
		$display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (90000) @(posedge clock);
		miscompares++;
		final_report();
	end

	initial begin
		cyc(5);
		rst = 1'b0;
		cyc(4);
		foreach (rows[k]) begin
			ascend = rows[k].asc;
			base   = wr_count;
			set_ptr(rows[k].ptr);
			for (int i = 0; i < NB; i++)
				put(8'(rows[k].d + i));
			u_master.stop_c();
			chk_val(8'(wr_count - base), 8'(NB));
			chk_val(reg_addr[15:8], 8'((rows[k].ptr + rows[k].step * NB) >> 8));
			chk_val(reg_addr[7:0], 8'(rows[k].ptr + rows[k].step * NB));
			for (int i = 0; i < NB; i++)
				chk_val(mem[8'(rows[k].ptr + rows[k].step * i)], 8'(rows[k].d + i));
			set_ptr(rows[k].ptr);
			u_master.start_c();
			put({ADDR, 1'b1});
			for (int i = 0; i < NB; i++) begin
				u_master.rbyte(i == NB - 1, rd);
				chk_val(rd, 8'(rows[k].d + i));
			end
			cyc(4);
			chk_bit(sda_oe, 1'b0);
			u_master.stop_c();
		end
		// Reset in mid-run clears pointer and drive
		rst = 1'b1;
		cyc(3);
		rst = 1'b0;
		chk_val(reg_addr[15:8], 8'h00);
		chk_val(reg_addr[7:0], 8'h00);
		chk_bit(sda_oe, 1'b0);
		chk_bit(reg_wr, 1'h0);
		chk_val(reg_wdata, 8'h00);
		cyc(4);
		base = wr_count;
		u_master.start_c();
		u_master.wbyte({ADDR ^ 7'h01, 1'b0}, ack);
		chk_bit(ack, 1'b0);
		u_master.wbyte(8'h00, ack);
		chk_bit(ack, 1'b0);
		// Pointer load, then a data byte cut short by a repeated start
		set_ptr(16'h1235);
		for (int i = 0; i < 4; i++)
			u_master.bit_x(1'b0, ack);
		u_master.start_c();
		put({ADDR, 1'b1});
		u_master.rbyte(1'b1, rd);
		chk_val(rd, 8'(rows[0].d + 1));
		cyc(4);
		chk_bit(sda_oe, 1'b0);
		u_master.stop_c();
		chk_val(8'(wr_count - base), 8'h00);
		final_report();
	end
endmodule
`default_nettype wire
